// >>> rtl/ciot_pkg.sv
// constants for the card i/o offset translation block
package ciot_pkg;

  // ------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [5:0] IDX_MAP_ENABLE   = 6'h06;
  localparam logic [5:0] IDX_MAP0_STRT_LO = 6'h08;
  localparam logic [5:0] IDX_MAP0_STRT_HI = 6'h09;
  localparam logic [5:0] IDX_MAP0_END_LO  = 6'h0A;
  localparam logic [5:0] IDX_MAP0_END_HI  = 6'h0B;
  localparam logic [5:0] IDX_MAP1_STRT_LO = 6'h0C;
  localparam logic [5:0] IDX_MAP1_STRT_HI = 6'h0D;
  localparam logic [5:0] IDX_MAP1_END_LO  = 6'h0E;
  localparam logic [5:0] IDX_MAP1_END_HI  = 6'h0F;
  localparam logic [5:0] IDX_MAP0_OFF_LO  = 6'h36;
  localparam logic [5:0] IDX_MAP0_OFF_HI  = 6'h37;
  localparam logic [5:0] IDX_MAP1_OFF_LO  = 6'h38;
  localparam logic [5:0] IDX_MAP1_OFF_HI  = 6'h39;
  localparam logic [5:0] IDX_HIT_STATUS   = 6'h3A;

  // ------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------
  localparam int unsigned IDX_LSB     = 2;
  localparam int unsigned IDX_MSB     = 7;
  localparam int unsigned NUM_MAPS    = 2;
  localparam int unsigned IO_ADDR_W   = 16;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [1:0]  RST_ENABLE  = 2'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : ciot_pkg

// >>> rtl/ciot_map_if.sv
// carrier between the register bank and one map translation unit
interface ciot_map_if;
  logic        en;
  logic [15:0] start;
  logic [15:0] stop;
  logic [15:0] offset;
  logic        hit;
  logic [15:0] card_addr;

  modport cfg  (output en, start, stop, offset, input hit, card_addr);
  modport unit (input en, start, stop, offset, output hit, card_addr);
endinterface : ciot_map_if

// >>> rtl/ciot_map_unit.sv
// window compare and offset add for one i/o map
module ciot_map_unit
(
  input  wire logic [15:0] i_sys_addr,
  ciot_map_if.unit         map
);

  // ------------------------------------------------------------
  // window compare
  // ------------------------------------------------------------
  // inclusive window check
  assign map.hit = map.en && (i_sys_addr >= map.start)
                          && (i_sys_addr <= map.stop);

  // ------------------------------------------------------------
  // translation
  // ------------------------------------------------------------
  // add map offset
  assign map.card_addr = 16'(i_sys_addr + map.offset);

endmodule // ciot_map_unit

// >>> rtl/ciot_offset_bank.sv
// card i/o offset register bank with axi4-lite slave and translation
module ciot_offset_bank
#(
  parameter int unsigned AXI_ADDR_W = 8
)
(
  input  wire logic                  i_core_clk,
  input  wire logic                  i_sys_rst,
  input  wire logic [AXI_ADDR_W-1:0] i_awaddr,
  input  wire logic                  i_awvalid,
  output      logic                  o_awready,
  input  wire logic [31:0]           i_wdata,
  input  wire logic [3:0]            i_wstrb,
  input  wire logic                  i_wvalid,
  output      logic                  o_wready,
  output      logic [1:0]            o_bresp,
  output      logic                  o_bvalid,
  input  wire logic                  i_bready,
  input  wire logic [AXI_ADDR_W-1:0] i_araddr,
  input  wire logic                  i_arvalid,
  output      logic                  o_arready,
  output      logic [31:0]           o_rdata,
  output      logic [1:0]            o_rresp,
  output      logic                  o_rvalid,
  input  wire logic                  i_rready,
  input  wire logic                  i_io_req,
  input  wire logic [15:0]           i_io_addr,
  output      logic                  o_card_req,
  output      logic [15:0]           o_card_addr,
  output      logic                  o_card_map,
  output      logic                  o_io_miss
);

  if (AXI_ADDR_W < 8)
  begin : g_chk
    $error("AXI_ADDR_W must be at least 8");
  end

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic [1:0]  map_en_r;
  logic [7:0]  strt_lo_r [ciot_pkg::NUM_MAPS];
  logic [7:0]  strt_hi_r [ciot_pkg::NUM_MAPS];
  logic [7:0]  end_lo_r  [ciot_pkg::NUM_MAPS];
  logic [7:0]  end_hi_r  [ciot_pkg::NUM_MAPS];
  logic [7:0]  off_lo_r  [ciot_pkg::NUM_MAPS];
  logic [7:0]  off_hi_r  [ciot_pkg::NUM_MAPS];
  logic [1:0]  hit_stat_r;
  logic [1:0]  hits;

  // ------------------------------------------------------------
  // map units
  // ------------------------------------------------------------
  ciot_map_if maps [ciot_pkg::NUM_MAPS] ();

  for (genvar m = 0; m < ciot_pkg::NUM_MAPS; m++)
  begin : g_map
    assign maps[m].en     = map_en_r[m];
    assign maps[m].start  = {strt_hi_r[m], strt_lo_r[m]};
    assign maps[m].stop   = {end_hi_r[m], end_lo_r[m]};
    assign maps[m].offset = {off_hi_r[m], off_lo_r[m]};
    assign hits[m]        = maps[m].hit;
    ciot_map_unit u_map
    (
      .i_sys_addr (i_io_addr),
      .map        (maps[m])
    );
  end

  // ------------------------------------------------------------
  // axi4-lite write channel
  // ------------------------------------------------------------
  logic                  aw_held_r;
  logic                  w_held_r;
  logic [5:0]            wr_idx_r;
  logic [7:0]            wr_byte_r;
  logic                  wr_lane_r;
  logic                  bvalid_r;
  logic [1:0]            bresp_r;
  logic                  wr_fire;
  logic                  wr_hit;

  assign o_awready = !aw_held_r && !bvalid_r;
  assign o_wready  = !w_held_r && !bvalid_r;
  assign o_bvalid  = bvalid_r;
  assign o_bresp   = bresp_r;
  assign wr_fire   = aw_held_r && w_held_r && !bvalid_r;

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      wr_idx_r  <= 6'h00;
      wr_byte_r <= ciot_pkg::RST_BYTE;
      wr_lane_r <= 1'b0;
    end
    else
    begin
      if (i_awvalid && o_awready)
      begin
        aw_held_r <= 1'b1;
        wr_idx_r  <= i_awaddr[ciot_pkg::IDX_MSB:ciot_pkg::IDX_LSB];
      end
      else if (wr_fire)
        aw_held_r <= 1'b0;
      if (i_wvalid && o_wready)
      begin
        w_held_r  <= 1'b1;
        wr_byte_r <= i_wdata[7:0];
        wr_lane_r <= i_wstrb[0];
      end
      else if (wr_fire)
        w_held_r <= 1'b0;
    end
  end

  // decode of indices that answer a write with okay (hit status included)
  always_comb
  begin
    case (wr_idx_r)
      ciot_pkg::IDX_MAP_ENABLE,
      ciot_pkg::IDX_MAP0_STRT_LO, ciot_pkg::IDX_MAP0_STRT_HI,
      ciot_pkg::IDX_MAP0_END_LO,  ciot_pkg::IDX_MAP0_END_HI,
      ciot_pkg::IDX_MAP1_STRT_LO, ciot_pkg::IDX_MAP1_STRT_HI,
      ciot_pkg::IDX_MAP1_END_LO,  ciot_pkg::IDX_MAP1_END_HI,
      ciot_pkg::IDX_MAP0_OFF_LO,  ciot_pkg::IDX_MAP0_OFF_HI,
      ciot_pkg::IDX_MAP1_OFF_LO,  ciot_pkg::IDX_MAP1_OFF_HI,
      ciot_pkg::IDX_HIT_STATUS:  wr_hit = 1'b1;
      default:                   wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= ciot_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? ciot_pkg::RESP_OKAY : ciot_pkg::RESP_SLVERR;
    end
    else if (i_bready)
      bvalid_r <= 1'b0;
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      map_en_r <= ciot_pkg::RST_ENABLE;
      for (int m = 0; m < ciot_pkg::NUM_MAPS; m++)
      begin
        strt_lo_r[m] <= ciot_pkg::RST_BYTE;
        strt_hi_r[m] <= ciot_pkg::RST_BYTE;
        end_lo_r[m]  <= ciot_pkg::RST_BYTE;
        end_hi_r[m]  <= ciot_pkg::RST_BYTE;
        off_lo_r[m]  <= ciot_pkg::RST_BYTE;
        off_hi_r[m]  <= ciot_pkg::RST_BYTE;
      end
    end
    else if (wr_fire && wr_lane_r)
    begin
      case (wr_idx_r)
        ciot_pkg::IDX_MAP_ENABLE:   map_en_r     <= wr_byte_r[1:0];
        ciot_pkg::IDX_MAP0_STRT_LO: strt_lo_r[0] <= wr_byte_r;
        ciot_pkg::IDX_MAP0_STRT_HI: strt_hi_r[0] <= wr_byte_r;
        ciot_pkg::IDX_MAP0_END_LO:  end_lo_r[0]  <= wr_byte_r;
        ciot_pkg::IDX_MAP0_END_HI:  end_hi_r[0]  <= wr_byte_r;
        ciot_pkg::IDX_MAP1_STRT_LO: strt_lo_r[1] <= wr_byte_r;
        ciot_pkg::IDX_MAP1_STRT_HI: strt_hi_r[1] <= wr_byte_r;
        ciot_pkg::IDX_MAP1_END_LO:  end_lo_r[1]  <= wr_byte_r;
        ciot_pkg::IDX_MAP1_END_HI:  end_hi_r[1]  <= wr_byte_r;
        ciot_pkg::IDX_MAP0_OFF_LO:  off_lo_r[0]  <= wr_byte_r;
        ciot_pkg::IDX_MAP1_OFF_LO:  off_lo_r[1]  <= wr_byte_r;
        ciot_pkg::IDX_MAP0_OFF_HI:  off_hi_r[0]  <= wr_byte_r;
        ciot_pkg::IDX_MAP1_OFF_HI:  off_hi_r[1]  <= wr_byte_r;
        default:                    map_en_r     <= map_en_r;
      endcase
    end
  end

  // ------------------------------------------------------------
  // axi4-lite read channel
  // ------------------------------------------------------------
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [7:0]  rd_byte;
  logic        rd_hit;
  logic [5:0]  rd_idx;

  assign o_arready = !rvalid_r;
  assign o_rvalid  = rvalid_r;
  assign o_rdata   = rdata_r;
  assign o_rresp   = rresp_r;
  assign rd_idx    = i_araddr[ciot_pkg::IDX_MSB:ciot_pkg::IDX_LSB];

  always_comb
  begin
    rd_hit = 1'b1;
    case (rd_idx)
      ciot_pkg::IDX_MAP_ENABLE:   rd_byte = {6'h00, map_en_r};
      ciot_pkg::IDX_MAP0_STRT_LO: rd_byte = strt_lo_r[0];
      ciot_pkg::IDX_MAP0_STRT_HI: rd_byte = strt_hi_r[0];
      ciot_pkg::IDX_MAP0_END_LO:  rd_byte = end_lo_r[0];
      ciot_pkg::IDX_MAP0_END_HI:  rd_byte = end_hi_r[0];
      ciot_pkg::IDX_MAP1_STRT_LO: rd_byte = strt_lo_r[1];
      ciot_pkg::IDX_MAP1_STRT_HI: rd_byte = strt_hi_r[1];
      ciot_pkg::IDX_MAP1_END_LO:  rd_byte = end_lo_r[1];
      ciot_pkg::IDX_MAP1_END_HI:  rd_byte = end_hi_r[1];
      ciot_pkg::IDX_MAP0_OFF_LO:  rd_byte = off_lo_r[0];
      ciot_pkg::IDX_MAP0_OFF_HI:  rd_byte = off_hi_r[0];
      ciot_pkg::IDX_MAP1_OFF_LO:  rd_byte = off_lo_r[1];
      ciot_pkg::IDX_MAP1_OFF_HI:  rd_byte = off_hi_r[1];
      ciot_pkg::IDX_HIT_STATUS:   rd_byte = {6'h00, hit_stat_r};
      default:
      begin
        rd_byte = 8'h00;
        rd_hit  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= ciot_pkg::RESP_OKAY;
    end
    else if (i_arvalid && o_arready)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h00_0000, rd_byte};
      rresp_r  <= rd_hit ? ciot_pkg::RESP_OKAY : ciot_pkg::RESP_SLVERR;
    end
    else if (i_rready)
      rvalid_r <= 1'b0;
  end

  // ------------------------------------------------------------
  // translated access output
  // ------------------------------------------------------------
  // map 0 wins when windows overlap
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_card_req  <= 1'b0;
      o_io_miss   <= 1'b0;
      o_card_addr <= 16'h0000;
      o_card_map  <= 1'b0;
      hit_stat_r  <= 2'h0;
    end
    else
    begin
      o_card_req <= i_io_req && (hits != 2'h0);
      o_io_miss  <= i_io_req && (hits == 2'h0);
      if (i_io_req)
      begin
        hit_stat_r <= hits;
        o_card_map <= !hits[0] && hits[1];
        o_card_addr <= hits[0] ? maps[0].card_addr : maps[1].card_addr;
      end
    end
  end

endmodule // ciot_offset_bank

// >>> verification/ciot_offset_checker.sv
// port assertions for the card i/o offset bank
module ciot_offset_checker
(
  input wire logic        i_core_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic        o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic        i_io_req,
  input wire logic        o_card_req,
  input wire logic        o_io_miss,
  input wire logic [15:0] o_card_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  sequence wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence rd_taken;
    i_arvalid && o_arready;
  endsequence
  wr_answer_a: assert property (wr_taken |-> ##2 o_bvalid)
    else $error("write answer not on time");
  rd_answer_a: assert property (rd_taken |=> o_rvalid)
    else $error("read answer not on time");
  rd_byte_a: assert property (o_rvalid |-> o_rdata[31:8] == 24'h000000)
    else $error("read data above byte not zero");
  io_answer_a: assert property (i_io_req |=> o_card_req ^ o_io_miss)
    else $error("access without single answer");
  io_quiet_a: assert property (!i_io_req |=> !o_card_req && !o_io_miss)
    else $error("answer without access");
  addr_hold_a: assert property (!i_io_req |=> $stable(o_card_addr))
    else $error("card address moved without access");
endmodule // ciot_offset_checker

bind ciot_offset_bank ciot_offset_checker i_chk
(
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
  .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid),
  .i_arvalid(i_arvalid), .o_arready(o_arready),
  .o_rvalid(o_rvalid), .o_rdata(o_rdata), .i_io_req(i_io_req),
  .o_card_req(o_card_req), .o_io_miss(o_io_miss),
  .o_card_addr(o_card_addr)
);

// >>> verification/ciot_card_model.sv
// pc card i/o space model: records card-side accesses
module ciot_card_model
(
  input  wire logic        i_core_clk,
  input  wire logic        i_card_req,
  input  wire logic [15:0] i_card_addr,
  output      logic [15:0] o_last_addr,
  output      logic [7:0]  o_n_access
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] n_r = 8'h00;
  assign o_n_access = n_r;
  always @(posedge i_core_clk)
    if (i_card_req)
    begin
      o_last_addr <= i_card_addr;
      n_r         <= n_r + 8'h01;
    end
endmodule // ciot_card_model

// >>> verification/tb_card_io_offset_translate.sv
// self-checking bench for the card i/o offset bank
module tb_card_io_offset_translate;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic        awv = 1'b0;
  logic        wv = 1'b0;
  logic        bready = 1'b0;
  logic        arv = 1'b0;
  logic        rready = 1'b0;
  logic        io_req = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic        awrdy, wrdy, bvalid, arrdy, rvalid;
  logic        card_req, card_map, io_miss;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] card_addr, last_addr;
  logic [7:0]  n_access;
  int          n_mismatch = 0;
  int          checks = 0;
  always #10 clk = ~clk;

  ciot_offset_bank i_dut
  (
    .i_core_clk(clk), .i_sys_rst(rst), .i_awaddr(awaddr),
    .i_awvalid(awv), .o_awready(awrdy), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wrdy), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arv), .o_arready(arrdy), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_io_req(io_req), .i_io_addr(io_addr), .o_card_req(card_req),
    .o_card_addr(card_addr), .o_card_map(card_map), .o_io_miss(io_miss)
  );
  ciot_card_model i_card
  (
    .i_core_clk(clk), .i_card_req(card_req), .i_card_addr(card_addr),
    .o_last_addr(last_addr), .o_n_access(n_access)
  );

  task automatic chk(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 40)
    begin
      n_mismatch++;
      $display("wrong value bus answer expected in time seen none");
      end_of_test();
    end
  endtask
  task automatic wr(input logic [5:0] ix, input logic [7:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= {ix, 2'h0};
    wdata  <= {24'h000000, d};
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (awrdy)
        awv <= 1'b0;
      if (wrdy)
        wv <= 1'b0;
      if (bvalid)
        break;
    end
    r = bresp;
    bready <= 1'b0;
    tmo(n);
  endtask
  task automatic rd(input logic [5:0] ix, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= {ix, 2'h0};
    arv    <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (arrdy)
        arv <= 1'b0;
      if (rvalid)
        break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    tmo(n);
  endtask
  task automatic t_regs();
    logic [7:0]  v [4] = '{8'h34, 8'h12, 8'h00, 8'hFF};
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 4; i++)
    begin
      rd(ciot_pkg::IDX_MAP0_OFF_LO + 6'(i), d, r);
      chk("offset reset", d, 32'h00000000);
      wr(ciot_pkg::IDX_MAP0_OFF_LO + 6'(i), v[i], r);
      chk("write resp", {30'h0, r}, {30'h0, ciot_pkg::RESP_OKAY});
    end
    for (int i = 0; i < 4; i++)
    begin
      rd(ciot_pkg::IDX_MAP0_OFF_LO + 6'(i), d, r);
      chk("offset back", d, {24'h000000, v[i]});
    end
    rd(6'h20, d, r);
    chk("unmapped rd", {30'h0, r}, {30'h0, ciot_pkg::RESP_SLVERR});
    wr(6'h20, 8'h55, r);
    chk("unmapped wr", {30'h0, r}, {30'h0, ciot_pkg::RESP_SLVERR});
    $display("register test done");
  endtask
  task automatic t_xlate();
    logic [7:0]  w [8] = '{8'h00, 8'h01, 8'hFF, 8'h01,
                           8'h00, 8'h03, 8'h0F, 8'h03};
    logic [15:0] a [8] = '{16'h00FF, 16'h0100, 16'h01FF, 16'h0200,
                           16'h02FF, 16'h0300, 16'h030F, 16'h0310};
    logic [1:0]  k [8] = '{2'h0, 2'h1, 2'h1, 2'h0,
                           2'h0, 2'h2, 2'h2, 2'h0};
    logic [15:0] off [3] = '{16'h0000, 16'h1234, 16'hFF00};
    logic [1:0]  r;
    for (int i = 0; i < 8; i++)
      wr(ciot_pkg::IDX_MAP0_STRT_LO + 6'(i), w[i], r);
    wr(ciot_pkg::IDX_MAP_ENABLE, 8'h03, r);
    for (int i = 0; i <= 8; i++)
    begin
      io_req  <= (i < 8);
      io_addr <= a[i % 8];
      @(posedge clk);
      if (i > 0)
      begin
        chk("hit", {31'h0, card_req}, {31'h0, k[i-1] != 2'h0});
        chk("miss", {31'h0, io_miss}, {31'h0, k[i-1] == 2'h0});
        if (k[i-1] != 2'h0)
        begin
          chk("map", {31'h0, card_map}, {31'h0, k[i-1] == 2'h2});
          chk("card addr", {16'h0, card_addr},
              {16'h0, a[i-1] + off[k[i-1]]});
        end
      end
    end
    @(posedge clk);
    chk("card count", {24'h0, n_access}, 32'h00000004);
    chk("card last", {16'h0, last_addr}, 32'h0000020F);
    $display("translation test done");
  endtask
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      rd(ciot_pkg::IDX_MAP0_OFF_LO + 6'(i), d, r);
      chk("offset re-reset", d, 32'h00000000);
    end
    io_req  <= 1'b1;
    io_addr <= 16'h0000;
    @(posedge clk);
    io_req  <= 1'b0;
    @(posedge clk);
    chk("disabled hit", {31'h0, card_req}, 32'h00000000);
    chk("disabled miss", {31'h0, io_miss}, 32'h00000001);
    $display("reset test done");
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_xlate();
    t_reset();
    end_of_test();
  end
endmodule // tb_card_io_offset_translate
